// File: hic_top.sv
// Purpose: Host port mode select and control for a multi-channel line device
// Assumes: Pins asynchronous to SYS_CLK_IN; shift clock much slower than it
// Notes:   Straps are captured once, at the end of the reset process
module hic_top (
  input  wire logic        SYS_CLK_IN,           // 20 MHz system clock
  input  wire logic        SRST_IN,              // Synchronous reset, high
  input  wire logic        HW_RST_N_IN,          // Hardware reset pin, low
  input  wire logic        IF_KIND_IN,           // Serial/parallel strap
  input  wire logic        STYLE_SEL_IN,         // Parallel style strap
  input  wire logic        MUX_SEL_IN,           // Multiplex strap
  input  wire logic        CS_N_IN,              // Chip select, low
  input  wire logic        STROBE_A_N_IN,        // Shift clock, data or read strobe
  input  wire logic        STROBE_B_IN,          // Serial in, direction or write
  input  wire logic        ALE_IN,               // Address latch pin
  input  wire logic [10:0] ADDR_IN,              // Address pins
  input  wire logic [7:0]  DATA_IN,              // Data bus, input side
  output logic      [7:0]  DATA_OUT,             // Data bus, output side
  output logic             DATA_OE_OUT,          // Data bus driven
  output logic             RESP_OUT,             // Serial out, ack or ready
  output logic             RESP_OE_OUT,          // Response pin driven
  input  wire logic [1:0]  GP_IN,                // General-purpose pins, input
  output logic      [1:0]  GP_OUT,               // General-purpose pins, output
  output logic      [1:0]  GP_OE_OUT,            // General-purpose pins driven
  input  wire logic [7:0]  IRQ_PEND_IN,          // Pending sources, same clock
  input  wire logic [7:0]  IRQ_MASK_IN,          // Source masks, high masks
  output logic             INT_OUT,              // Interrupt pin level
  output logic             INT_OE_OUT,           // Interrupt pin driven
  output logic             BUSY_OUT,             // Reset process running
  output logic [1:0]       MODE_OUT              // Sampled host port mode
);

  // Access phase of the host port
  typedef enum logic [1:0]
  {
    PH_IDLE,
    PH_ACTIVE,
    PH_DONE
  } hic_phase_t;

  // Whole module state
  typedef struct packed
  {
    logic [7:0]         rst_cnt;     // Reset process counter
    hic_pkg::hic_strap_t strap;      // Captured straps
    hic_pkg::hic_mode_t mode;        // Host port mode
    hic_phase_t         phase;       // Access phase
    logic [10:0]        addr;        // Latched address
    logic [7:0]         gpio;        // General-purpose register
    logic [7:0]         gcfg;        // Global configuration register
    logic [7:0]         rdata;       // Read data pipeline
    logic               resp;        // Response pin level
    logic               data_oe;     // Data bus drive enable
    logic [4:0]         bit_cnt;     // Serial bit counter
    logic [15:0]        shift;       // Serial shift register
    logic               sout;        // Serial output bit
    logic               prev_sclk;   // Shift clock history
    logic               prev_ale;    // Latch pin history
    logic               prev_cs;     // Chip select history
  } hic_state_t;

  hic_state_t st;                    // Registered state
  hic_state_t next_st;               // Next state
  hic_pkg::hic_pbus_t pb;            // Synchronised bus pins
  logic [1:0]  gp_s;                 // Synchronised general-purpose pins
  logic [3:0]  strap_s;              // Synchronised straps and reset pin
  logic [7:0]  scratch [hic_pkg::REG_DEPTH]; // Other register storage
  logic        wr_en;                // Scratch write this cycle
  logic [10:0] wr_addr;              // Scratch write address
  logic [7:0]  wr_data;              // Scratch write data
  logic        irq_any;              // Unmasked pending source

  // Every pin except the interrupt source and mask inputs crosses two stages before logic sees it
  hic_sync #(.WIDTH(23)) u_bus_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (SRST_IN),
    .async_in ({CS_N_IN, STROBE_A_N_IN, STROBE_B_IN, ALE_IN, ADDR_IN, DATA_IN}),
    .sync_out (pb)
  );

  hic_sync #(.WIDTH(6)) u_misc_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (SRST_IN),
    .async_in ({GP_IN, HW_RST_N_IN, IF_KIND_IN, STYLE_SEL_IN, MUX_SEL_IN}),
    .sync_out ({gp_s, strap_s})
  );

  // Register read decode, shared by serial and parallel paths
  function automatic logic [7:0] rd_reg(input logic [10:0] a, input logic [7:0] g,
                                        input logic [7:0] c, input logic [1:0] pin);
    logic [7:0] v;
    v = '0;
    if (a == hic_pkg::GPIO_ADDR)
    begin
      v = g;
      for (int i = 0; i < 2; i++)
      begin
        if (!g[hic_pkg::GP_DIR_LSB + i])
          v[hic_pkg::GP_LVL_LSB + i] = pin[i];
      end
    end
    else if (a == hic_pkg::GCFG_ADDR)
      v = c;
    else
      v = '0;
    return v;
  endfunction

  // Next-state logic
  always_comb
  begin
    logic       sclk_rise;
    logic       sclk_fall;
    logic       ale_fall;
    logic       cs_fall;
    logic       wr_now;
    logic [7:0] wv;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    ale_fall  = 1'b0;
    cs_fall   = 1'b0;
    wr_now    = 1'b0;
    wv        = '0;
    next_st   = st;
    wr_en     = 1'b0;
    wr_addr   = st.addr;
    wr_data   = '0;
    next_st.prev_sclk = pb.strobe_a_n;
    next_st.prev_ale  = pb.ale;
    next_st.prev_cs   = pb.cs_n;
    sclk_rise = !st.prev_sclk && pb.strobe_a_n;
    sclk_fall = st.prev_sclk && !pb.strobe_a_n;
    ale_fall  = st.prev_ale && !pb.ale;
    cs_fall   = st.prev_cs && !pb.cs_n;
    if (!strap_s[3])
    begin
      // Hardware reset pin low restarts the reset process
      next_st.rst_cnt = hic_pkg::RST_CYC_W;
      next_st.gpio    = hic_pkg::GPIO_RST;
      next_st.gcfg    = hic_pkg::GCFG_RST;
      next_st.phase   = PH_IDLE;
      next_st.resp    = 1'b1;
      next_st.data_oe = 1'b0;
    end
    else if (st.rst_cnt != '0)
    begin
      next_st.rst_cnt = st.rst_cnt - 8'h01;
      if (st.rst_cnt == 8'h01)
      begin
        // Straps captured once as the process ends
        next_st.strap = {strap_s[2], strap_s[1], strap_s[0]};
        if (!strap_s[2])
          next_st.mode = hic_pkg::HIC_SERIAL;
        else if (strap_s[1])
          next_st.mode = hic_pkg::HIC_SEP_STROBE;
        else
          next_st.mode = hic_pkg::HIC_DIR_STROBE;
      end
    end
    else if (pb.cs_n)
    begin
      // Deselected: port idle, responses released
      next_st.phase   = PH_IDLE;
      next_st.data_oe = 1'b0;
      next_st.bit_cnt = '0;
      next_st.resp    = (st.mode == hic_pkg::HIC_SERIAL) ? 1'b0 : 1'b1;
    end
    else if (st.mode == hic_pkg::HIC_SERIAL)
    begin
      // Serial: bit 15 read flag, 14..8 address, 7..0 data
      if (cs_fall)
        next_st.bit_cnt = '0;
      else if (sclk_rise && st.bit_cnt != hic_pkg::SER_BITS_W)
      begin
        next_st.shift   = {st.shift[14:0], pb.strobe_b};
        next_st.bit_cnt = st.bit_cnt + 5'h01;
        if (st.bit_cnt == 5'h07)
        begin
          next_st.addr  = {4'h0, st.shift[5:0], pb.strobe_b};
          next_st.rdata = rd_reg({4'h0, st.shift[5:0], pb.strobe_b}, st.gpio, st.gcfg, gp_s);
        end
        if (st.bit_cnt == 5'h0F && !st.shift[14])
          wr_now = 1'b1;
      end
      else if (sclk_fall && st.bit_cnt >= 5'h08)
      begin
        next_st.sout  = st.rdata[7];
        next_st.rdata = {st.rdata[6:0], 1'b0};
      end
      wv = {st.shift[6:0], pb.strobe_b};
      next_st.resp = next_st.sout;
    end
    else
    begin
      // Parallel address capture: shared bus when multiplexed, address pins otherwise
      if (st.strap.multiplexed && ale_fall)
        next_st.addr = {pb.addr[10:8], pb.data};
      else if (!st.strap.multiplexed)
        next_st.addr = pb.addr;
      case (st.phase)
        PH_IDLE:
        begin
          if (cs_fall)
            next_st.phase = PH_ACTIVE;
        end
        PH_ACTIVE:
        begin
          if (st.mode == hic_pkg::HIC_DIR_STROBE && !pb.strobe_a_n)
          begin
            if (pb.strobe_b)
            begin
              next_st.rdata   = rd_reg(st.addr, st.gpio, st.gcfg, gp_s);
              next_st.data_oe = 1'b1;
            end
            else
              wr_now = 1'b1;
            next_st.phase = PH_DONE;
            next_st.resp  = 1'b0;
          end
          else if (st.mode == hic_pkg::HIC_SEP_STROBE && (!pb.strobe_a_n || !pb.strobe_b))
          begin
            next_st.resp = 1'b0;
            if (!pb.strobe_a_n)
            begin
              next_st.rdata   = rd_reg(st.addr, st.gpio, st.gcfg, gp_s);
              next_st.data_oe = 1'b1;
            end
            next_st.phase = PH_DONE;
          end
        end
        PH_DONE:
        begin
          if (st.mode == hic_pkg::HIC_SEP_STROBE)
          begin
            next_st.resp = 1'b1;
            if (pb.strobe_a_n && pb.strobe_b)
            begin
              next_st.data_oe = 1'b0;
              if (!st.data_oe)
                wr_now = 1'b1;
              next_st.phase = PH_IDLE;
            end
          end
          else if (pb.strobe_a_n)
          begin
            next_st.resp    = 1'b1;
            next_st.data_oe = 1'b0;
            next_st.phase   = PH_IDLE;
          end
        end
        default:
          next_st.phase = PH_IDLE;
      endcase
      wv = pb.data;
    end
    // Register write, shared by all modes
    if (wr_now)
    begin
      if (st.addr == hic_pkg::GPIO_ADDR)
        next_st.gpio = wv;
      else if (st.addr == hic_pkg::GCFG_ADDR)
        next_st.gcfg = wv;
      else
      begin
        wr_en   = 1'b1;
        wr_data = wv;
      end
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
    begin
      st           <= '0;
      st.rst_cnt   <= hic_pkg::RST_CYC_W;
      st.gpio      <= hic_pkg::GPIO_RST;
      st.gcfg      <= hic_pkg::GCFG_RST;
      st.resp      <= 1'b1;
      st.prev_cs   <= 1'b1;
      st.prev_ale  <= 1'b1;
      st.prev_sclk <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Scratch registers; not reset, contents undefined until written
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (wr_en)
      scratch[wr_addr[3:0]] <= wr_data;
  end

  // Interrupt combine of unmasked sources
  assign irq_any = |(IRQ_PEND_IN & ~IRQ_MASK_IN);

  // Bit 3 high: push-pull; bit 2 high: active high
  assign INT_OUT    = (irq_any == st.gcfg[hic_pkg::INT_PIN_LSB]);
  assign INT_OE_OUT = st.gcfg[hic_pkg::INT_PIN_LSB + 1] | irq_any;

  // General-purpose pins: drive only when configured as output
  generate
    for (genvar g = 0; g < 2; g++)
    begin : gp_pin
      assign GP_OE_OUT[g] = st.gpio[hic_pkg::GP_DIR_LSB + g];
      assign GP_OUT[g]    = st.gpio[hic_pkg::GP_LVL_LSB + g];
    end
  endgenerate

  // Port outputs from registers
  assign DATA_OUT    = st.rdata;
  assign DATA_OE_OUT = st.data_oe && !pb.cs_n;
  assign RESP_OUT    = st.resp;
  assign RESP_OE_OUT = (st.rst_cnt == '0);
  assign BUSY_OUT    = (st.rst_cnt != '0);
  assign MODE_OUT    = st.mode;

endmodule

// File: hic_pkg.sv
// Purpose: Shared constants and carriers for the host interface control block
// Assumes: 20 MHz system clock, pin inputs asynchronous to it
// Notes:   Register storage behind the port is a small local array
package hic_pkg;

  // Clock and reset timing
  localparam int unsigned CLK_HZ         = 20000000;  // System clock rate
  localparam int unsigned RST_MAX_NS     = 2000;      // Longest reset process
  localparam int unsigned RST_CYC        = (RST_MAX_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [7:0]  RST_CYC_W      = 8'(RST_CYC); // Reset count at counter width

  // Address and data widths
  localparam int unsigned ADDR_W         = 11;        // Parallel address width
  localparam int unsigned DATA_W         = 8;         // Data bus width
  localparam int unsigned HI_ADDR_LSB    = 8;         // Upper address pins A10..A8

  // Local register map
  localparam logic [10:0] GPIO_ADDR      = 11'h000;   // General-purpose register
  localparam logic [10:0] GCFG_ADDR      = 11'h001;   // Global configuration register
  localparam int unsigned REG_DEPTH      = 16;        // Scratch array depth

  // General-purpose register fields
  localparam int unsigned GP_DIR_LSB     = 0;         // Direction bits 1..0
  localparam int unsigned GP_LVL_LSB     = 2;         // Level bits 3..2
  localparam logic [7:0]  GPIO_RST       = 8'h00;     // Both pins input after reset

  // Global configuration fields
  localparam int unsigned INT_PIN_LSB    = 2;         // Interrupt pin mode bits 3..2
  localparam logic [7:0]  GCFG_RST       = 8'h00;     // Open drain, active low

  // Serial framing: one command byte, one data byte
  localparam int unsigned SER_BITS       = 16;        // Bits per serial frame
  localparam logic [4:0]  SER_BITS_W     = 5'(SER_BITS);

  // Host port mode after strap sampling
  typedef enum logic [1:0]
  {
    HIC_SERIAL,
    HIC_DIR_STROBE,
    HIC_SEP_STROBE
  } hic_mode_t;

  // Sampled straps
  typedef struct packed
  {
    logic      parallel;     // Interface kind strap
    logic      sep_style;    // High selects separate read/write strobes
    logic      multiplexed;  // High selects multiplexed address/data
  } hic_strap_t;

  // Parallel bus pins after synchronisation
  typedef struct packed
  {
    logic                cs_n;
    logic                strobe_a_n;  // Data strobe or read strobe
    logic                strobe_b;    // Direction select or write strobe
    logic                ale;         // Address latch pin
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } hic_pbus_t;

endpackage

// File: hic_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of asynchronous pins
// Assumes: Single system clock, synchronous reset
// Notes:   First stage is read only by the second stage
module hic_sync #(
  parameter int unsigned WIDTH = 1               // Number of bits synchronised
) (
  input  wire logic             clk_in,          // System clock
  input  wire logic             rst_in,          // Synchronous reset, high
  input  wire logic [WIDTH-1:0] async_in,        // Raw pin levels
  output logic      [WIDTH-1:0] sync_out         // Levels after two stages
);

  logic [WIDTH-1:0] meta;                        // First stage, metastable

  // Two stages; reset values are constants only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// File: hic_top_asserts.sv
// Purpose: Concurrent checks on the host port pins of hic_top
// Assumes: One clock domain; SRST_IN disables every check
// Notes:   Margins cover the two-stage pin synchronisers
module hic_top_asserts (
  input  wire logic       SYS_CLK_IN,     // System clock
  input  wire logic       SRST_IN,        // Synchronous reset
  input  wire logic       HW_RST_N_IN,    // Hardware reset pin
  input  wire logic       CS_N_IN,        // Chip select
  input  wire logic       STROBE_A_N_IN,  // Data or read strobe
  input  wire logic [7:0] IRQ_PEND_IN,    // Pending sources
  input  wire logic [7:0] IRQ_MASK_IN,    // Source masks
  input  wire logic       DATA_OE_OUT,    // Data bus driven
  input  wire logic       RESP_OUT,       // Ack or ready
  input  wire logic [1:0] GP_OE_OUT,      // Pin drive enables
  input  wire logic       INT_OE_OUT,     // Interrupt pin driven
  input  wire logic       BUSY_OUT,       // Reset process running
  input  wire logic [1:0] MODE_OUT        // Sampled mode
);
  localparam int BUSY_MAX = 45;  // 40 cycle process plus sync lag
  logic [6:0] busy_cnt;          // Busy cycles since reset pin release

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);

  // Held reset pin legally restarts the process, so count from release
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN || !HW_RST_N_IN || !BUSY_OUT)
      busy_cnt <= 7'h00;
    else
      busy_cnt <= busy_cnt + 7'h01;
  end

  a_busy_bound: assert property (busy_cnt <= BUSY_MAX)
    else $error("reset process ran too long");
  a_rst_clear: assert property (BUSY_OUT [*3] |-> GP_OE_OUT == 2'h0 && !DATA_OE_OUT)
    else $error("pins driven during reset process");
  a_idle_no_drive: assert property (CS_N_IN [*5] |-> !DATA_OE_OUT)
    else $error("data bus driven without chip select");
  a_idle_gp_hold: assert property ((CS_N_IN && HW_RST_N_IN && !BUSY_OUT) [*6] |->
    $stable(GP_OE_OUT))
    else $error("pin directions changed without an access");
  a_int_raise: assert property ($rose(|(IRQ_PEND_IN & ~IRQ_MASK_IN)) && !BUSY_OUT |->
    ##[0:3] (INT_OE_OUT || !(|(IRQ_PEND_IN & ~IRQ_MASK_IN))))
    else $error("unmasked source did not drive interrupt pin");
  a_mode_static: assert property (!BUSY_OUT && !$past(BUSY_OUT) |-> $stable(MODE_OUT))
    else $error("mode changed outside reset");
  a_serial_quiet: assert property (MODE_OUT == 2'h0 && !BUSY_OUT |-> !DATA_OE_OUT)
    else $error("data bus driven in serial mode");
  a_ack_release: assert property ((MODE_OUT == 2'h1 && !BUSY_OUT && STROBE_A_N_IN) [*5]
    |-> RESP_OUT)
    else $error("acknowledge held without strobe");
  a_ready_idle: assert property ((MODE_OUT == 2'h2 && !BUSY_OUT && CS_N_IN) [*5]
    |-> RESP_OUT)
    else $error("ready low while idle");
endmodule

// File: hic_host_model.sv
// Purpose: Host processor model for the parallel and serial port of hic_top
// Assumes: Straps sampled already; bench calls access between resets
// Notes:   A released data bus toggles, never keeps the last value
module hic_host_model (
  input  wire logic       clk_in,      // System clock
  input  wire logic       resp_in,     // Ack or ready level
  input  wire logic       resp_oe_in,  // Response pin driven
  input  wire logic [7:0] dout_in,     // Device read data
  input  wire logic       doe_in,      // Device drives data bus
  output logic            cs_n_out,    // Chip select
  output logic            sa_n_out,    // Data or read strobe
  output logic            sb_out,      // Direction or write strobe
  output logic            ale_out,     // Address latch
  output logic [10:0]     addr_out,    // Address pins
  output logic [7:0]      bus_out      // Resolved data bus level
);
  logic [7:0] hd = 8'h00;    // Host data
  logic       hoe = 1'b0;    // Host drives the bus
  logic [7:0] last = 8'h00;  // Previous bus level

  // Floating bus shows a changing pattern so no stale value passes
  assign bus_out = doe_in ? dout_in : (hoe ? hd : ~last);
  always @(posedge clk_in) last <= bus_out;

  // Idle levels; latch pin held high as on a non-multiplexed bus
  initial
  begin
    cs_n_out = 1'b1;
    sa_n_out = 1'b1;
    sb_out   = 1'b1;
    ale_out  = 1'b1;
    addr_out = 11'h000;
  end

  // One access; sep picks strobe style, mux adds the address phase
  task automatic access(input logic sep, mux, rd, ign, input logic [10:0] a,
                        input logic [7:0] wd, output logic [7:0] rv);
    int n;
    @(posedge clk_in);
    cs_n_out <= ign;      // Fresh falling edge per access unless ign keeps select high
    addr_out <= mux ? {a[10:8], ~a[7:0]} : a; // Low pins carry junk when shared
    hd       <= a[7:0];
    hoe      <= mux;
    sb_out   <= sep | rd; // Direction settled before strobe
    repeat (4) @(posedge clk_in);
    ale_out  <= !mux;     // Falling edge latches in mux mode
    repeat (4) @(posedge clk_in);
    hd       <= wd;
    hoe      <= !rd;
    sa_n_out <= sep & !rd;
    sb_out   <= rd;
    // Wait for ack, or ready low; bounded so a silent device cannot hang
    for (n = 0; n < 30; n++)
    begin
      @(posedge clk_in);
      if (resp_oe_in && !resp_in) break;
    end
    if (sep)
      for (n = 0; n < 30; n++)
      begin
        @(posedge clk_in);
        if (resp_in) break;
      end
    rv = bus_out;
    sa_n_out <= 1'b1;
    sb_out   <= sep | rd;
    @(posedge clk_in);
    cs_n_out <= 1'b1;     // Select kept low until done
    ale_out  <= 1'b1;
    repeat (4) @(posedge clk_in);
    hoe      <= 1'b0;     // Late release covers commit on strobe release
  endtask

  // Serial frame, MSB first; shift clock idles high and stops between frames
  task automatic serial(input logic [15:0] fr, output logic [7:0] rv);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 15; i >= 0; i--)
    begin
      sa_n_out <= 1'b0;   // Device updates its output on this fall
      sb_out   <= fr[i];
      repeat (4) @(posedge clk_in);
      sa_n_out <= 1'b1;   // Device samples the input on this rise
      repeat (4) @(posedge clk_in);
      if (i < 8)
        rv[i] = resp_in;  // Settled long after the fall
    end
    cs_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for hic_top
// Assumes: Host model drives the port; straps change only around resets
// Notes:   Serial mode gets one register round trip, as do parallel ones
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;          // 20 MHz clock
  logic        srst = 1'b1;         // Synchronous reset
  logic        hw_rst_n = 1'b1;     // Hardware reset pin
  logic [2:0]  straps = 3'h2;       // Kind, style, multiplex
  logic [1:0]  gp_ext = 2'h0;       // Outside level on pins
  logic [7:0]  pend = 8'h00;        // Pending sources
  logic [7:0]  mask = 8'hFF;        // Source masks
  logic        cs_n, sa_n, sb, ale, resp, resp_oe, doe, int_o, int_oe, busy;
  logic [10:0] addr;                // Address pins
  logic [7:0]  bus, dout, rv;       // Data bus, device data, read value
  logic [1:0]  gp_out, gp_oe, mode; // Pin outputs and mode
  int          errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  hic_top i_hic_top (.SYS_CLK_IN(clk), .SRST_IN(srst), .HW_RST_N_IN(hw_rst_n),
    .IF_KIND_IN(straps[2]), .STYLE_SEL_IN(straps[1]), .MUX_SEL_IN(straps[0]),
    .CS_N_IN(cs_n), .STROBE_A_N_IN(sa_n), .STROBE_B_IN(sb), .ALE_IN(ale),
    .ADDR_IN(addr), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_OUT(doe),
    .RESP_OUT(resp), .RESP_OE_OUT(resp_oe), .GP_IN(gp_oe & gp_out | ~gp_oe & gp_ext),
    .GP_OUT(gp_out), .GP_OE_OUT(gp_oe), .IRQ_PEND_IN(pend), .IRQ_MASK_IN(mask),
    .INT_OUT(int_o), .INT_OE_OUT(int_oe), .BUSY_OUT(busy), .MODE_OUT(mode));

  hic_host_model i_hic_host_model (.clk_in(clk), .resp_in(resp), .resp_oe_in(resp_oe),
    .dout_in(dout), .doe_in(doe), .cs_n_out(cs_n), .sa_n_out(sa_n), .sb_out(sb),
    .ale_out(ale), .addr_out(addr), .bus_out(bus));

  always #25 clk = ~clk;

  // Hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait out the reset process, bounded
  task automatic wait_idle();
    for (int n = 0; n < 80; n++)
    begin
      @(posedge clk);
      if (n > 2 && !busy) break;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(posedge clk);
    straps <= s;
    srst   <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    wait_idle();
  endtask

  task automatic acc(input logic rd, ign, input logic [10:0] a, input logic [7:0] wd);
    i_hic_host_model.access(straps[1], straps[0], rd, ign, a, wd, rv);
  endtask

  // Level field: output bits echo the write, input bits show the pin
  function automatic logic [7:0] gp_exp(input logic [3:0] w, input logic [1:0] pin);
    return {4'h0, (w[3:2] & w[1:0]) | (pin & ~w[1:0]), w[1:0]};
  endfunction

  // Interrupt pin as {driven, level while driven}
  function automatic logic [7:0] int_exp(input logic [1:0] g, input logic [7:0] p, m);
    logic act;
    logic oe;
    act = |(p & ~m);
    oe  = g[1] | act;
    return {6'h00, oe, oe & (act ~^ g[0])};
  endfunction

  initial
  begin
    logic [2:0] modes [5] = '{3'h2, 3'h4, 3'h6, 3'h7, 3'h5};
    logic [1:0] mexp [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
    logic [7:0] w;
    void'($urandom(32'hE80CD6E0));
    // All four parallel strap combinations and one serial, each with a register round trip
    for (int i = 0; i < 5; i++)
    begin
      do_reset(modes[i]);
      check({6'h00, mode}, {6'h00, mexp[i]});
      w = {4'h0, 4'($urandom)};
      gp_ext <= 2'($urandom);
      if (modes[i][2])
      begin
        acc(1'b0, 1'b0, hic_pkg::GPIO_ADDR, w);
        acc(1'b1, 1'b0, hic_pkg::GPIO_ADDR, 8'h00);
      end
      else
      begin
        i_hic_host_model.serial({1'b0, 7'(hic_pkg::GPIO_ADDR), w}, rv);
        i_hic_host_model.serial({1'b1, 7'(hic_pkg::GPIO_ADDR), 8'h00}, rv);
      end
      check({4'h0, rv[3:0]}, gp_exp(w[3:0], gp_ext));
      check({4'h0, gp_oe, gp_out & gp_oe}, {4'h0, w[1:0], w[3:2] & w[1:0]});
    end
    // Write with select high must be ignored
    acc(1'b0, 1'b1, hic_pkg::GPIO_ADDR, {4'h0, ~w[3:0]});
    acc(1'b1, 1'b0, hic_pkg::GPIO_ADDR, 8'h00);
    check({4'h0, rv[3:0]}, gp_exp(w[3:0], gp_ext));
    // All four driver modes; first draw is all pending but all masked
    for (int g = 0; g < 4; g++)
    begin
      acc(1'b0, 1'b0, hic_pkg::GCFG_ADDR, 8'(g << hic_pkg::INT_PIN_LSB));
      for (int k = 0; k < 4; k++)
      begin
        pend <= (k == 0) ? 8'hFF : (k == 3) ? 8'h00 : 8'($urandom);
        mask <= (k == 0) ? 8'hFF : (k == 3) ? 8'h00 : 8'($urandom);
        repeat (5) @(posedge clk);
        check({6'h00, int_oe, int_o & int_oe}, int_exp(2'(g), pend, mask));
      end
    end
    // Hardware reset pulse: busy starts, ends in time, pins back to input
    hw_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    hw_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({7'h00, busy}, 8'h01);
    // 40-cycle process starts two pin stages after release
    repeat (39) @(posedge clk);
    check({7'h00, busy}, 8'h00);
    wait_idle();
    acc(1'b1, 1'b0, hic_pkg::GPIO_ADDR, 8'h00);
    check({4'h0, rv[3:0]}, gp_exp(4'h0, gp_ext));
    end_of_test();
  end
endmodule

bind hic_top hic_top_asserts i_hic_top_asserts (.SYS_CLK_IN(SYS_CLK_IN),
  .SRST_IN(SRST_IN), .HW_RST_N_IN(HW_RST_N_IN), .CS_N_IN(CS_N_IN),
  .STROBE_A_N_IN(STROBE_A_N_IN), .IRQ_PEND_IN(IRQ_PEND_IN), .IRQ_MASK_IN(IRQ_MASK_IN),
  .DATA_OE_OUT(DATA_OE_OUT), .RESP_OUT(RESP_OUT), .GP_OE_OUT(GP_OE_OUT),
  .INT_OE_OUT(INT_OE_OUT), .BUSY_OUT(BUSY_OUT), .MODE_OUT(MODE_OUT));
